// file: common/eeprom_guard_pkg.sv
// constants, types and state codes shared by the serial eeprom slave
// assumes a 200 MHz system clock and a bus master on the two-wire link
package eeprom_guard_pkg;

   localparam int          CLK_PERIOD_NS = 5;
   localparam int          PROG_TIME_NS  = 5000000;   // internal_program_time, longest
   localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int          TIMER_W       = 20;
   localparam int          ADDR_W        = 8;
   localparam int          PAGE_BYTES    = 16;
   localparam int          MEM_WORDS     = 256;
   localparam int          PIN_W         = 6;

   localparam logic [3:0]  TYPE_MEM      = 4'hA;
   localparam logic [3:0]  TYPE_PROT     = 4'h6;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam logic [3:0]  LAST_BIT      = 4'h7;
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
   localparam logic [7:0]  ADDR_RESET    = 8'h00;
   localparam logic [7:0]  ADDR_STEP     = 8'h01;
   localparam logic [3:0]  NIBBLE_STEP   = 4'h1;
   localparam int          UPPER_HALF    = 7;        // address bit that marks 80h..FFh

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_RX     = 6'h02,
      ST_RX_ACK = 6'h04,
      ST_TX     = 6'h08,
      ST_TX_ACK = 6'h10,
      ST_WAIT   = 6'h20
   } state_t;

   typedef enum logic [1:0] {
      K_DEV  = 2'h0,
      K_WORD = 2'h1,
      K_DATA = 2'h2,
      K_LOCK = 2'h3
   } kind_t;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic       wp;
      logic [2:0] dev_sel;
   } pins_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } rd_entry_t;

endpackage : eeprom_guard_pkg

// file: design/line_sync.sv
// two flip-flop synchroniser for a group of asynchronous pin levels
// assumes levels that stay put for several system clocks
`timescale 1ns/1ps
module line_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk_sys,   // system clock
   input  wire logic         i_srst,      // sync reset, active high
   input  wire logic [W-1:0] i_d,         // asynchronous levels
   output logic      [W-1:0] o_q          // synchronised levels
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t r;
   sync_t next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = i_d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_q = r.s2;

endmodule : line_sync

// file: design/serial_eeprom_read_and_write_guard.sv
// two-wire slave of a 256-byte eeprom: reads, write guard, polling, abort
// assumes the master's clock and data are slow against the 200 MHz system clock
// Function
// R1 - random read returns the byte at the word address just written
// R2 - after any read the internal address is last accessed plus one
// R3 - current read returns the byte at the internal address
// R4 - random and current reads may continue as sequential reads
// R5 - master ack low without stop makes the next byte follow, whole array
// R6 - master no-ack ends output, releases data, waits for stop
// R7 - master ends a read with ack high then a stop
// R8 - master only releases data during software reset dummy clocks
// R9 - during internal programming all commands ignored, no address ack
// R10 - ack to polling means programming done, no ack means busy
// R11 - after polling ack the master continues in the same transaction
// R12 - write-protect ignored from start until first data lsb is sampled
// R13 - write-protect high from that edge to programming end cancels write
// R14 - write-protect high during programming halts it, location undefined
// R15 - cancelled write returns straight to standby, no programming wait
// R16 - start then stop during command input aborts the command
// R17 - master uses software reset while the device may hold data low
// R18 - aborted read leaves internal address undefined; use random read
// R19 - respond only when address bits equal the select pins
// R20 - write-protect high allows reads only, low allows both
// R21 - data line only pulled low, otherwise released
// R22 - type 1010 selects memory, 0110 the protect register, lsb read/write; 0110 with lsb 1 (read) gets no ack
// R23 - receiver pulls data low on ninth clock to acknowledge
// R24 - sequential address wraps from last location to zero
// R25 - read bytes leave msb first, data changing only while clock low
`timescale 1ns/1ps
module serial_eeprom_read_and_write_guard #(
   parameter int PROG_CYCLES = eeprom_guard_pkg::PROG_CYCLES
) (
   input  wire logic i_clk_sys,       // system clock 200 MHz
   input  wire logic i_srst,          // sync reset, active high
   input  wire logic i_scl,           // serial clock pin
   input  wire logic i_sda,           // data pin level
   input  wire logic i_wp,            // write-protect pin
   input  wire logic i_dev_sel_bit0,  // address select pin 0
   input  wire logic i_dev_sel_bit1,  // address select pin 1
   input  wire logic i_dev_sel_bit2,  // address select pin 2
   output logic      o_sda,           // data drive value, always low
   output logic      o_sda_oe_n,      // low while pulling data low
   output logic      o_busy           // internal programming running
);

   typedef struct packed {
      eeprom_guard_pkg::state_t                      st;
      eeprom_guard_pkg::kind_t                       kind;
      logic [3:0]                                    bit_cnt;
      logic [7:0]                                    shreg;
      logic [7:0]                                    addr;
      logic [7:0]                                    fetch_addr;
      logic                                          rd_mode;
      logic                                          master_ack;
      logic                                          sda_drive;
      logic                                          sda_oe_n;
      logic [3:0]                                    page;
      logic [eeprom_guard_pkg::PAGE_BYTES-1:0]       pvalid;
      logic                                          wp_armed;
      logic                                          cancel;
      logic                                          busy;
      logic [eeprom_guard_pkg::TIMER_W-1:0]          timer;
      logic                                          lock;
      logic                                          lock_pend;
      logic                                          prev_scl;
      logic                                          prev_sda;
   } core_t;

   core_t                       r;
   core_t                       next_r;
   eeprom_guard_pkg::pins_t     pin;
   eeprom_guard_pkg::rd_entry_t fill_word;
   eeprom_guard_pkg::rd_entry_t head_word;
   logic                        fill_ready;
   logic                        head_valid;
   logic                        pop;
   logic                        pg_we;
   logic                        commit;
   logic                        scl_rise;
   logic                        scl_fall;
   logic                        start_cond;
   logic                        stop_cond;
   logic [7:0]                  mem [eeprom_guard_pkg::MEM_WORDS];
   logic [7:0]                  pg_data [eeprom_guard_pkg::PAGE_BYTES];

   function automatic logic [7:0] next_addr(input logic [7:0] a);
      next_addr = a + eeprom_guard_pkg::ADDR_STEP;   // [R24]
   endfunction : next_addr

   function automatic logic addr_match(input logic [7:0] b, input logic [2:0] sel);
      addr_match = (b[3:1] == sel);
   endfunction : addr_match

   line_sync #(
      .W(eeprom_guard_pkg::PIN_W)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_d       ({i_scl, i_sda, i_wp, i_dev_sel_bit2, i_dev_sel_bit1, i_dev_sel_bit0}),
      .o_q       (pin)
   );

   assign fill_word.addr = r.fetch_addr;
   assign fill_word.data = mem[r.fetch_addr];

   two_entry_buffer u_buf (
      .i_clk_sys   (i_clk_sys),
      .i_srst      (i_srst),
      .i_flush     (~r.rd_mode),
      .i_in_valid  (r.rd_mode),
      .o_in_ready  (fill_ready),
      .i_in        (fill_word),
      .o_out_valid (head_valid),
      .i_out_ready (pop),
      .o_out       (head_word)
   );

   assign scl_rise   = pin.scl & ~r.prev_scl;
   assign scl_fall   = ~pin.scl & r.prev_scl;
   assign start_cond = pin.scl & r.prev_scl & r.prev_sda & ~pin.sda;
   assign stop_cond  = pin.scl & r.prev_scl & ~r.prev_sda & pin.sda;

   always_comb begin
      next_r          = r;
      next_r.prev_scl = pin.scl;
      next_r.prev_sda = pin.sda;
      pop             = 1'b0;
      pg_we           = 1'b0;
      commit          = 1'b0;

      if (r.rd_mode && fill_ready) begin
         next_r.fetch_addr = next_addr(r.fetch_addr);                 // [R5]
      end

      if (r.busy) begin
         if (pin.wp) begin
            next_r.busy   = 1'b0;                                     // [R14] [R15]
            next_r.pvalid = '0;
         end else if (r.timer == '0) begin
            commit        = 1'b1;
            next_r.busy   = 1'b0;
            next_r.pvalid = '0;
         end else begin
            next_r.timer = r.timer - 1'b1;
         end
      end

      if (r.kind == eeprom_guard_pkg::K_DATA
          && r.wp_armed && pin.wp) begin
         next_r.cancel = 1'b1;                                        // [R13] [R20]
      end

      if (start_cond) begin
         next_r.st       = eeprom_guard_pkg::ST_RX;                   // [R16] [R18]
         next_r.kind     = eeprom_guard_pkg::K_DEV;
         next_r.bit_cnt  = '0;
         next_r.rd_mode  = 1'b0;
         next_r.sda_oe_n = 1'b1;
         next_r.cancel   = 1'b0;
         next_r.wp_armed = 1'b0;                                      // [R12]
         next_r.lock_pend = 1'b0;
         if (!r.busy) begin
            next_r.pvalid = '0;
         end
      end else if (stop_cond) begin
         next_r.st       = eeprom_guard_pkg::ST_IDLE;                 // [R7] [R16]
         next_r.rd_mode  = 1'b0;
         next_r.sda_oe_n = 1'b1;
         if (r.lock_pend) begin
            next_r.lock = 1'b1;
         end
         if (r.kind == eeprom_guard_pkg::K_DATA && r.pvalid != '0 && !r.busy) begin
            if (r.cancel || (r.lock && !r.page[3])) begin
               next_r.pvalid = '0;                                    // [R13] [R15] [R20]
            end else begin
               next_r.busy  = 1'b1;
               next_r.timer = eeprom_guard_pkg::TIMER_W'(PROG_CYCLES - 1);
            end
         end
         next_r.kind = eeprom_guard_pkg::K_DEV;
      end else begin
         unique case (r.st)
            eeprom_guard_pkg::ST_IDLE, eeprom_guard_pkg::ST_WAIT: begin
               next_r.sda_oe_n = 1'b1;
            end
            eeprom_guard_pkg::ST_RX: begin
               if (scl_rise && r.bit_cnt != eeprom_guard_pkg::BITS_PER_BYTE) begin
                  next_r.shreg   = {r.shreg[6:0], pin.sda};
                  next_r.bit_cnt = r.bit_cnt + 1'b1;
                  if (r.kind == eeprom_guard_pkg::K_DATA
                      && r.bit_cnt == eeprom_guard_pkg::LAST_BIT && !r.wp_armed) begin
                     next_r.wp_armed = 1'b1;                          // [R12] [R13]
                     if (pin.wp) begin
                        next_r.cancel = 1'b1;
                     end
                  end
               end else if (scl_fall && r.bit_cnt == eeprom_guard_pkg::BITS_PER_BYTE) begin
                  next_r.st       = eeprom_guard_pkg::ST_RX_ACK;
                  next_r.sda_oe_n = 1'b0;                             // [R23]
                  unique case (r.kind)
                     eeprom_guard_pkg::K_DEV: begin
                        if (r.busy || !addr_match(r.shreg, pin.dev_sel)
                            || (r.shreg[7:4] != eeprom_guard_pkg::TYPE_MEM
                                && !(r.shreg[7:4] == eeprom_guard_pkg::TYPE_PROT
                                     && !r.shreg[0]))) begin
                           next_r.st       = eeprom_guard_pkg::ST_IDLE; // [R9] [R10] [R19]
                           next_r.sda_oe_n = 1'b1;
                        end else if (r.shreg[7:4] == eeprom_guard_pkg::TYPE_PROT) begin
                           next_r.kind = eeprom_guard_pkg::K_LOCK;    // [R22]
                        end else if (r.shreg[0]) begin
                           next_r.rd_mode    = 1'b1;                  // [R3] [R22] [R11]
                           next_r.fetch_addr = r.addr;
                        end else begin
                           next_r.kind = eeprom_guard_pkg::K_WORD;
                        end
                     end
                     eeprom_guard_pkg::K_WORD: begin
                        next_r.addr = r.shreg;                        // [R1]
                        next_r.page = r.shreg[7:4];
                        next_r.kind = eeprom_guard_pkg::K_DATA;
                     end
                     eeprom_guard_pkg::K_DATA: begin
                        pg_we = 1'b1;
                        next_r.pvalid[r.addr[3:0]] = 1'b1;
                        next_r.addr = {r.page, r.addr[3:0] + eeprom_guard_pkg::NIBBLE_STEP};
                     end
                     eeprom_guard_pkg::K_LOCK: begin
                        next_r.lock_pend = 1'b1;
                     end
                  endcase
               end
            end
            eeprom_guard_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  next_r.bit_cnt = '0;
                  if (r.rd_mode && head_valid) begin
                     pop             = 1'b1;                          // [R1] [R3]
                     next_r.st       = eeprom_guard_pkg::ST_TX;
                     next_r.shreg    = head_word.data;
                     next_r.addr     = next_addr(head_word.addr);     // [R2]
                     next_r.sda_oe_n = head_word.data[7];             // [R25] [R21]
                  end else begin
                     next_r.st       = eeprom_guard_pkg::ST_RX;
                     next_r.sda_oe_n = 1'b1;
                  end
               end
            end
            eeprom_guard_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (r.bit_cnt == eeprom_guard_pkg::LAST_BIT) begin
                     next_r.st       = eeprom_guard_pkg::ST_TX_ACK;
                     next_r.sda_oe_n = 1'b1;
                  end else begin
                     next_r.shreg    = {r.shreg[6:0], 1'b0};
                     next_r.bit_cnt  = r.bit_cnt + 1'b1;
                     next_r.sda_oe_n = r.shreg[6];                    // [R25] [R21] [R8]
                  end
               end
            end
            eeprom_guard_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  next_r.master_ack = ~pin.sda;                       // [R23]
               end else if (scl_fall) begin
                  if (r.master_ack && head_valid) begin
                     pop             = 1'b1;                          // [R4] [R5]
                     next_r.st       = eeprom_guard_pkg::ST_TX;
                     next_r.bit_cnt  = '0;
                     next_r.shreg    = head_word.data;
                     next_r.addr     = next_addr(head_word.addr);     // [R2] [R24]
                     next_r.sda_oe_n = head_word.data[7];
                  end else begin
                     next_r.st      = eeprom_guard_pkg::ST_WAIT;      // [R6] [R17]
                     next_r.rd_mode = 1'b0;
                  end
               end
            end
            default: begin
               next_r.st       = eeprom_guard_pkg::ST_IDLE;
               next_r.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         r           <= '0;
         r.st        <= eeprom_guard_pkg::ST_IDLE;
         r.kind      <= eeprom_guard_pkg::K_DEV;
         r.addr      <= eeprom_guard_pkg::ADDR_RESET;
         r.sda_oe_n  <= 1'b1;
         r.prev_scl  <= 1'b0;
         r.prev_sda  <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (pg_we) begin
         pg_data[r.addr[3:0]] <= r.shreg;
      end
   end

   // array commits the page bytes marked in pvalid in the cycle programming ends
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         for (int i = 0; i < eeprom_guard_pkg::MEM_WORDS; i++) begin
            mem[i] <= eeprom_guard_pkg::ERASED_BYTE;
         end
      end else if (commit) begin
         for (int j = 0; j < eeprom_guard_pkg::PAGE_BYTES; j++) begin
            if (r.pvalid[j]) begin
               mem[{r.page, 4'(j)}] <= pg_data[j];
            end
         end
      end
   end

   assign o_sda      = r.sda_drive;
   assign o_sda_oe_n = r.sda_oe_n;
   assign o_busy     = r.busy;

endmodule : serial_eeprom_read_and_write_guard

// file: design/two_entry_buffer.sv
// two-entry buffer between the array fetch and the bit shifter
// assumes the consumer pops only while o_out_valid is high
`timescale 1ns/1ps
module two_entry_buffer (
   input  wire logic                       i_clk_sys,   // system clock
   input  wire logic                       i_srst,      // sync reset, active high
   input  wire logic                       i_flush,     // drop both entries
   input  wire logic                       i_in_valid,  // fill side offers a word
   output logic                            o_in_ready,  // room for a word
   input  wire eeprom_guard_pkg::rd_entry_t i_in,       // word offered
   output logic                            o_out_valid, // head word present
   input  wire logic                       i_out_ready, // drain side takes head
   output eeprom_guard_pkg::rd_entry_t     o_out        // head word
);

   typedef struct packed {
      logic                        v0;
      logic                        v1;
      eeprom_guard_pkg::rd_entry_t e0;
      eeprom_guard_pkg::rd_entry_t e1;
   } buf_t;

   buf_t r;
   buf_t next_r;
   logic push;
   logic pop;

   assign push = i_in_valid & ~r.v1;
   assign pop  = i_out_ready & r.v0;

   always_comb begin
      next_r = r;
      if (i_flush) begin
         next_r.v0 = 1'b0;
         next_r.v1 = 1'b0;
      end else begin
         if (pop) begin
            next_r.e0 = r.e1;
            next_r.v0 = r.v1;
            next_r.v1 = 1'b0;
         end
         if (push) begin
            if (!next_r.v0) begin
               next_r.e0 = i_in;
               next_r.v0 = 1'b1;
            end else begin
               next_r.e1 = i_in;
               next_r.v1 = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_in_ready  = ~r.v1;
   assign o_out_valid = r.v0;
   assign o_out       = r.e0;

endmodule : two_entry_buffer

// file: test/eeprom_guard_chk.sv
// port checker for the two-wire eeprom slave
// assumes it is bound to the slave top module; one clock domain
`timescale 1ns/1ps
module eeprom_guard_chk #(
   parameter int PROG_CYCLES = 200
) (
   input wire logic i_clk_sys,      // system clock
   input wire logic i_srst,         // sync reset, active high
   input wire logic i_scl,          // serial clock pin
   input wire logic i_sda,          // resolved data wire
   input wire logic i_wp,           // write-protect pin
   input wire logic i_dev_sel_bit0, // select pin 0
   input wire logic i_dev_sel_bit1, // select pin 1
   input wire logic i_dev_sel_bit2, // select pin 2
   input wire logic o_sda,          // data drive value
   input wire logic o_sda_oe_n,     // low while pulling data low
   input wire logic o_busy          // programming running
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   int busy_len;
   always_ff @(posedge i_clk_sys) begin
      if (i_srst || !o_busy) busy_len <= 0;
      else busy_len <= busy_len + 1;
   end
   sequence s_prog_begin;
      $rose(o_busy);
   endsequence
   a_drive_only_low: assert property (o_sda == 1'b0)
      else $error("data drive value not low");
   a_oe_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
      else $error("data drive changed while clock high");
   a_oe_holds_bit: assert property ($changed(o_sda_oe_n) |=> $stable(o_sda_oe_n)[*8])
      else $error("data drive did not hold for the bit");
   a_busy_no_ack: assert property (o_busy |-> o_sda_oe_n)
      else $error("data driven during programming");
   a_busy_bounded: assert property (busy_len <= PROG_CYCLES)
      else $error("programming ran too long");
   a_wp_halts_prog: assert property (o_busy && i_wp |-> ##[1:6] !o_busy)
      else $error("programming not halted by write protect");
   a_prog_after_stop: assert property (s_prog_begin |-> i_scl && i_sda)
      else $error("programming began without a stop");
   a_wp_no_prog: assert property (s_prog_begin |-> !$past(i_wp, 6))
      else $error("programming began under write protect");
   c_ack: cover property ($fell(o_sda_oe_n));
endmodule : eeprom_guard_chk

bind serial_eeprom_read_and_write_guard eeprom_guard_chk #(.PROG_CYCLES(PROG_CYCLES))
   u_eeprom_guard_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(i_scl),
   .i_sda(i_sda), .i_wp(i_wp), .i_dev_sel_bit0(i_dev_sel_bit0),
   .i_dev_sel_bit1(i_dev_sel_bit1), .i_dev_sel_bit2(i_dev_sel_bit2),
   .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));

// file: test/link_master.sv
// two-wire bus master model: serial clock and open-drain data
// assumes a pull-up on data; pins move 1 ns after a system clock edge
`timescale 1ns/1ps
module link_master #(
   parameter int HALF = 16
) (
   input  wire logic i_clk_sys, // system clock
   input  wire logic i_sda,     // resolved data wire
   output logic      o_scl,     // serial clock, high and still when idle
   output logic      o_sda_low  // high pulls data low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick
   // data set mid-low, sampled mid-high
   task automatic bit_io(input logic drv_low, output logic seen);
      o_scl = 1'b0;
      tick(HALF / 2);
      o_sda_low = drv_low;
      tick(HALF / 2);
      o_scl = 1'b1;
      tick(HALF / 2);
      seen = i_sda;
      tick(HALF / 2);
   endtask : bit_io
   task automatic start();
      o_scl = 1'b0;
      tick(HALF / 2);
      o_sda_low = 1'b0;
      tick(HALF / 2);
      o_scl = 1'b1;
      tick(HALF);
      o_sda_low = 1'b1;
      tick(HALF);
   endtask : start
   task automatic stop();
      o_scl = 1'b0;
      tick(HALF / 2);
      o_sda_low = 1'b1;
      tick(HALF / 2);
      o_scl = 1'b1;
      tick(HALF);
      o_sda_low = 1'b0;
      tick(2 * HALF);
   endtask : stop
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(!b[i], s);
      bit_io(1'b0, s);
      ack = !s;
   endtask : put_byte
   task automatic get_byte(output logic [7:0] b, input logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b0, b[i]);
      bit_io(!nack, s);
   endtask : get_byte
endmodule : link_master

// file: test/serial_eeprom_read_and_write_guard_tb.sv
// self-checking bench for the two-wire eeprom slave
// assumes the link master model and the bound port checker
`timescale 1ns/1ps
module serial_eeprom_read_and_write_guard_tb;
   localparam int PROG = 600;
   logic       clk, srst, wp, scl, sda_low, drv, oe_n, busy, sda_wire;
   logic [2:0] sel_pins;
   int         err_total, samples_checked, cyc;
   assign sda_wire = !sda_low && (oe_n || drv);
   serial_eeprom_read_and_write_guard #(.PROG_CYCLES(PROG)) u_serial_eeprom_read_and_write_guard (
      .i_clk_sys(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda_wire), .i_wp(wp),
      .i_dev_sel_bit0(sel_pins[0]), .i_dev_sel_bit1(sel_pins[1]),
      .i_dev_sel_bit2(sel_pins[2]), .o_sda(drv), .o_sda_oe_n(oe_n), .o_busy(busy));
   link_master u_link_master (.i_clk_sys(clk), .i_sda(sda_wire), .o_scl(scl),
      .o_sda_low(sda_low));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : chk
   function automatic logic [7:0] dev(input logic rw);
      return {eeprom_guard_pkg::TYPE_MEM, sel_pins, rw};
   endfunction : dev
   task automatic poll(input logic rw, output int tries);
      logic a;
      tries = 0;
      do begin
         tries++;
         u_link_master.start();
         u_link_master.put_byte(dev(rw), a);
         if (!a) u_link_master.stop();
      end while (!a && tries < 20);
      chk({7'h00, a}, 8'h01, "poll ack");
   endtask : poll
   task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
      int t;
      logic k;
      poll(1'b0, t);
      u_link_master.put_byte(a, k);
      foreach (d[i]) u_link_master.put_byte(d[i], k);
      u_link_master.stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
      int t;
      logic k;
      logic [7:0] b;
      poll(1'b0, t);
      u_link_master.put_byte(a, k);
      u_link_master.start();
      u_link_master.put_byte(dev(1'b1), k);
      foreach (e[i]) begin
         u_link_master.get_byte(b, i == e.size() - 1);
         chk(b, e[i], "read byte");
      end
      u_link_master.stop();
   endtask : rd
   task automatic t_seq();
      int t;
      logic k;
      logic [7:0] b;
      wr(8'h20, '{8'h5A, 8'hA5, 8'h3C});
      chk({7'h00, busy}, 8'h01, "busy after stop");
      u_link_master.start();
      u_link_master.put_byte(dev(1'b1), k);
      chk({7'h00, k}, 8'h00, "ack while busy");
      u_link_master.stop();
      rd(8'h20, '{8'h5A, 8'hA5, 8'h3C});
      rd(8'h20, '{8'h5A});
      poll(1'b1, t);
      u_link_master.get_byte(b, 1'b1);
      chk(b, 8'hA5, "current read");
      u_link_master.get_byte(b, 1'b1);
      chk(b, 8'hFF, "released after nack");
      u_link_master.stop();
      wr(8'hFF, '{8'h77});
      wr(8'h00, '{8'h66});
      rd(8'hFF, '{8'h77, 8'h66});
      $display("test seq done");
   endtask : t_seq
   task automatic t_wp();
      int t;
      logic k;
      wp = 1'b1;
      wr(8'h30, '{8'h11});
      chk({7'h00, busy}, 8'h00, "no busy when protected");
      poll(1'b0, t);
      chk(8'(t), 8'h01, "standby after cancel");
      u_link_master.put_byte(8'h31, k);
      wp = 1'b0;
      u_link_master.put_byte(8'h22, k);
      u_link_master.stop();
      chk({7'h00, busy}, 8'h01, "early protect ignored");
      rd(8'h30, '{8'hFF, 8'h22});
      wr(8'h40, '{8'h44});
      repeat (20) @(posedge clk);
      #1 wp = 1'b1;
      repeat (10) @(posedge clk);
      chk({7'h00, busy}, 8'h00, "programming halted");
      #1 wp = 1'b0;
      poll(1'b0, t);
      chk(8'(t), 8'h01, "standby after halt");
      u_link_master.stop();
      $display("test wp done");
   endtask : t_wp
   task automatic t_sel();
      logic k;
      logic [7:0] b;
      for (int p = 0; p < 2; p++) begin
         sel_pins = (p == 0) ? 3'h5 : 3'h2;
         for (int s = 0; s < 8; s++) begin
            u_link_master.start();
            u_link_master.put_byte({eeprom_guard_pkg::TYPE_MEM, 3'(s), 1'b1}, k);
            chk({7'h00, k}, {7'h00, 3'(s) == sel_pins}, "select");
            if (k) u_link_master.get_byte(b, 1'b1);
            u_link_master.stop();
         end
      end
      u_link_master.start();
      u_link_master.put_byte({eeprom_guard_pkg::TYPE_PROT, sel_pins, 1'b1}, k);
      chk({7'h00, k}, 8'h00, "protect read refused");
      u_link_master.stop();
      u_link_master.start();
      for (int i = 0; i < 3; i++) u_link_master.bit_io(i == 1, k);
      u_link_master.start();
      u_link_master.stop();
      chk({7'h00, busy}, 8'h00, "abort idle");
      rd(8'h20, '{8'h5A});
      $display("test sel done");
   endtask : t_sel
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         $display("[ERR] %0t run timed out", $time);
         conclude();
      end
   end
   initial begin
      srst = 1'b1;
      wp = 1'b0;
      sel_pins = 3'h5;
      err_total = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (3) @(posedge clk);
      #1 srst = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      t_seq();
      t_wp();
      t_sel();
      conclude();
   end
endmodule : serial_eeprom_read_and_write_guard_tb
